// >>> rll_consts.vh
// Constants for the 1,7 RLL encoder and synchroniser control block.
// Assumes a single system clock; the reference, VCO and write clock edges
// arrive as synchronous one-cycle ticks.
// Overview of operation
// - Each data pair becomes three code bits from present, next, prior.
// - 10100 around a one shifts it early, 00101 late, others none.
// - Late bit moves toward the following bit position.
// - Early bit moves toward the preceding bit position.
// - Precomp select 00,01,10,11 gives three, two, one, zero steps.
// - Idle/write run from reference; read decodes and clocks from VCO.
// - Read mode stays on the reference until the VCO has locked.
// - Low mark enable allows mark detection and mark generation.
// - Mark detect floats while writing or while enable is high.
// - A found mark latches detect low until enable goes high.
// - Direct write low: each falling data edge toggles write output.
// - Phase detect enable low: coast, VCO functions use the reference.
// - Low read gate selects read data as PLL reference, starts sync; code needs write gate high too, both low is idle.
// - In read mode select bits set shift size, direction input sets side.
// - Direction 0 gives early window, 1 gives late window.
// - Select 111 none, 110 4% through 000 22%.
// - Serial read output floats except while read gate is active; code also floats it when both gates are low.
// - Read clock source change makes no glitch, loses one pulse at most.
// - Read clock follows reference until 19 read pulses, then read data; code switches it to VCO ticks.
// - Reference active output high while reference drives timing.
// - Encoded write data is retimed to the reference clock.
// - Low write gate places the device in write mode; code needs read gate high too, both low is idle.
`ifndef RLL_CONSTS_VH
`define RLL_CONSTS_VH
`define RLL_LOCK_PULSES 5'h13
`define RLL_CLK_DIV 4'hc
`define RLL_PCOMP_STEP 3'h1
`define RLL_PCOMP_NOM 4'h3
`define RLL_CODE_BUF 3'h6
`endif

// >>> rll_ctl_model.sv
// Controller model: drives the gates and the NRZ write pins.
// Assumes the bench picks the mode; mode 3 is a deliberate fault.
`timescale 1ns/1ps
`default_nettype none
module rll_ctl_model (
    // Clock
    input wire logic clk_sys,
    // Requested mode and direct write data
    input wire logic [1:0] mode,
    input wire logic direct,
    input wire logic dbit,
    // Controller pins
    output logic write_gate_n,
    output logic read_gate_n,
    output logic write_clock_tick,
    output logic serial_write_in
);
    logic [3:0] pat_q = 4'h4;
    logic [3:0] div_q = 4'h0;
    logic [1:0] md;
    logic dr;
    logic db;
    // Pin levels at time zero, write data pulled up
    initial
    begin
        write_gate_n = 1'b1;
        read_gate_n = 1'b1;
        write_clock_tick = 1'b0;
        serial_write_in = 1'b1;
    end
    // Pins move just after the edge; data and its tick move together
    always @(posedge clk_sys)
    begin
        md = mode;
        dr = direct;
        db = dbit;
        #1;
        write_gate_n = !md[1];
        read_gate_n = !md[0];
        write_clock_tick = 1'b0;
        if (md != 2'h2)
        begin
            pat_q = 4'h4;
            div_q = 4'h0;
            serial_write_in = 1'b1;
        end
        else if (dr)
            serial_write_in = db;
        else if (div_q == 4'hb)
        begin
            div_q = 4'h0;
            serial_write_in = pat_q[3];
            write_clock_tick = 1'b1;
            pat_q = {pat_q[2:0], pat_q[3]};
        end
        else
            div_q = div_q + 4'h1;
    end
endmodule
`default_nettype wire

// >>> rll_enc.v
// 1,7 RLL encoder: one data pair in, one finished code word out.
// Assumes pairs arrive no faster than one per three reference ticks.
`timescale 1ns/1ps
`default_nettype none
module rll_enc (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    input wire clk_en,
    input wire clear,
    // Data pairs in
    input wire pair_valid,
    input wire [1:0] pair,
    // Code words out
    output reg word_valid,
    output reg [2:0] word
);
    reg [1:0] pres_q;
    reg have_pres_q;
    reg [2:0] prev_q;
    reg have_prev_q;
    reg [2:0] code;
    reg rewrite;

    // Table lookup on present pair, next pair and prior last bit
    always @*
    begin
        rewrite = 1'b0;
        case (pres_q)
            2'b01: code = (pair == 2'b00) ? 3'h5 :
                (pair == 2'b11) ? 3'h4 : 3'h2;
            2'b10: code = (pair == 2'b00) ? 3'h1 :
                (pair == 2'b11) ? 3'h0 : 3'h2;
            2'b00: code = {2'b00, ~pair[0]};
            default: code = 3'h2;
        endcase
        if (pair == 2'b10 && pres_q != 2'b00)
            rewrite = 1'b1;
    end

    // Hold one word back so its last bit may still be rewritten
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pres_q <= 2'h0;
            have_pres_q <= 1'b0;
            prev_q <= 3'h0;
            have_prev_q <= 1'b0;
            word_valid <= 1'b0;
            word <= 3'h0;
        end
        else if (clk_en)
        begin
            word_valid <= 1'b0;
            if (clear)
            begin
                have_pres_q <= 1'b0;
                have_prev_q <= 1'b0;
            end
            else if (pair_valid)
            begin
                pres_q <= pair;
                have_pres_q <= 1'b1;
                if (have_pres_q)
                begin
                    prev_q <= code;
                    have_prev_q <= 1'b1;
                    if (have_prev_q)
                    begin
                        word_valid <= 1'b1;
                        word <= {prev_q[2:1], prev_q[0] & ~rewrite};
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rll_endec_sync.v
// Digital side of the 1,7 RLL data synchroniser: mode decode, read clock
// source selection, address mark pins, write path and window shift.
// Assumes all ticks and pins are synchronous to clk_sys; the analog PLL
// and delay lines live outside.
`timescale 1ns/1ps
`default_nettype none
`include "rll_consts.vh"
module rll_endec_sync (
    // Clock, reset, enable
    input wire clk_sys,
    input wire reset,
    input wire clk_en,
    // Controller gates and modes
    input wire write_gate_n,
    input wire read_gate_n,
    input wire mark_search_enable_n,
    input wire direct_write_n,
    input wire phase_detect_enable,
    // Timing ticks
    input wire ref_tick,
    input wire vco_tick,
    input wire write_clock_tick,
    input wire read_pulse,
    // Write data and precomp
    input wire serial_write_in,
    input wire precomp_sel_lo,
    input wire precomp_sel_hi,
    // Window shift control
    input wire window_shift_sel0,
    input wire window_shift_sel1,
    input wire window_shift_sel2,
    input wire window_shift_dir,
    // Read side events
    input wire read_bit_in,
    input wire read_bit_valid,
    input wire mark_hit,
    // Write output
    output wire encoded_write_out,
    // Clock status
    output reg recovered_clock,
    output wire ref_clock_active,
    output wire phase_ref_is_read,
    output wire decode_from_vco,
    output wire phase_detect_on,
    // Serial read data pin
    output reg serial_read_out,
    output wire serial_read_oe_n,
    // Address mark pins
    output reg mark_found_n,
    output wire mark_found_oe_n,
    output wire mark_write_enable,
    // Window shift result
    output reg [4:0] window_shift_pct,
    output reg window_shift_late
);
    // Window shift magnitude in percent from active-low selects
    function [4:0] shift_pct;
        input [2:0] s;
        begin
            case (s)
                3'b111: shift_pct = 5'h00;
                3'b110: shift_pct = 5'h04;
                3'b101: shift_pct = 5'h08;
                3'b100: shift_pct = 5'h0c;
                3'b011: shift_pct = 5'h0f;
                3'b010: shift_pct = 5'h12;
                3'b001: shift_pct = 5'h14;
                default: shift_pct = 5'h16;
            endcase
        end
    endfunction

    localparam ST_IDLE = 2'b00;
    localparam ST_READ = 2'b01;
    localparam ST_WRITE = 2'b10;

    reg [1:0] mode_q;
    reg [1:0] mode_d;
    reg [4:0] pulse_cnt_q;
    reg locked_q;
    reg src_vco_q;
    reg [3:0] div_q;
    reg [1:0] cap_q;
    reg cap_half_q;
    reg pair_valid_q;
    reg [1:0] pair_q;
    reg [5:0] code_buf_q;
    reg [2:0] code_cnt_q;
    reg [5:0] code_buf_d;
    reg [2:0] code_cnt_d;
    reg swi_prev_q;
    reg [2:0] shifted_cnt;
    reg [5:0] shifted_buf;
    wire enc_valid;
    wire [2:0] enc_word;
    wire in_read;
    wire in_write;
    wire searching;
    wire direct;
    wire direct_toggle;
    wire want_vco;
    wire src_tick;
    wire bit_out;

    // Mode decode; both gates low falls back to idle
    always @*
    begin
        case ({write_gate_n, read_gate_n})
            2'b01: mode_d = ST_WRITE;
            2'b10: mode_d = ST_READ;
            2'b00: mode_d = ST_IDLE;
            default: mode_d = ST_IDLE;
        endcase
    end

    // Mode register
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            mode_q <= ST_IDLE;
        else if (clk_en)
            mode_q <= mode_d;
    end

    assign in_read = (mode_q == ST_READ);
    assign in_write = (mode_q == ST_WRITE);
    assign direct = in_write && !direct_write_n;

    // Read data pulses counted toward lock after the gate falls
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pulse_cnt_q <= 5'h00;
            locked_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!in_read)
            begin
                pulse_cnt_q <= 5'h00;
                locked_q <= 1'b0;
            end
            else if (read_pulse && !locked_q)
            begin
                pulse_cnt_q <= pulse_cnt_q + 5'h01;
                if (pulse_cnt_q + 5'h01 == `RLL_LOCK_PULSES)
                    locked_q <= 1'b1;
            end
        end
    end

    // VCO drives timing only when read, locked and not coasting
    assign want_vco = in_read && locked_q &&
        phase_detect_enable;
    assign phase_ref_is_read = in_read;
    assign phase_detect_on = phase_detect_enable;
    assign decode_from_vco = src_vco_q;
    assign ref_clock_active = ~src_vco_q;
    assign src_tick = src_vco_q ? vco_tick : ref_tick;

    // Divide-by-twelve read clock; source swaps only at a cycle start
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            div_q <= 4'h0;
            recovered_clock <= 1'b0;
            src_vco_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (div_q == 4'h0 && !recovered_clock &&
                src_vco_q != want_vco)
                src_vco_q <= want_vco;
            else if (src_tick)
            begin
                if (div_q == (`RLL_CLK_DIV >> 1) - 4'h1)
                begin
                    div_q <= 4'h0;
                    recovered_clock <= ~recovered_clock;
                end
                else
                    div_q <= div_q + 4'h1;
            end
        end
    end

    // Serial write data gathered into pairs on write clock ticks
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cap_q <= 2'h0;
            cap_half_q <= 1'b0;
            pair_valid_q <= 1'b0;
            pair_q <= 2'h0;
        end
        else if (clk_en)
        begin
            pair_valid_q <= 1'b0;
            if (!in_write || direct)
                cap_half_q <= 1'b0;
            else if (write_clock_tick)
            begin
                cap_q <= {cap_q[0], serial_write_in};
                cap_half_q <= ~cap_half_q;
                if (cap_half_q)
                begin
                    pair_q <= {cap_q[0], serial_write_in};
                    pair_valid_q <= 1'b1;
                end
            end
        end
    end

    // Encoder
    rll_enc u_enc (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .clear(!in_write || direct),
        .pair_valid(pair_valid_q),
        .pair(pair_q),
        .word_valid(enc_valid),
        .word(enc_word)
    );

    // Code bits leave one per reference tick, retimed to the reference
    always @*
    begin
        shifted_buf = code_buf_q;
        shifted_cnt = code_cnt_q;
        if (ref_tick && code_cnt_q != 3'h0)
        begin
            shifted_buf = {code_buf_q[4:0], 1'b0};
            shifted_cnt = code_cnt_q - 3'h1;
        end
        code_buf_d = shifted_buf;
        code_cnt_d = shifted_cnt;
        if (enc_valid && shifted_cnt <= `RLL_CODE_BUF - 3'h3)
        begin
            code_buf_d = shifted_buf | ({enc_word, 3'h0} >> shifted_cnt);
            code_cnt_d = shifted_cnt + 3'h3;
        end
        if (!in_write || direct)
        begin
            code_buf_d = 6'h00;
            code_cnt_d = 3'h0;
        end
    end

    // Code buffer registers
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            code_buf_q <= 6'h00;
            code_cnt_q <= 3'h0;
        end
        else if (clk_en)
        begin
            code_buf_q <= code_buf_d;
            code_cnt_q <= code_cnt_d;
        end
    end

    assign bit_out = (code_cnt_q != 3'h0) && code_buf_q[5];

    // Falling edges of serial data seen in direct write
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            swi_prev_q <= 1'b1; // Pin idles high, no false edge
        else if (clk_en)
            swi_prev_q <= serial_write_in;
    end

    assign direct_toggle = direct && swi_prev_q &&
        !serial_write_in;

    // Precompensation and write flip-flop
    rll_pcomp u_pcomp (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .bit_tick(ref_tick && in_write && !direct),
        .code_bit(bit_out),
        .sel({precomp_sel_hi, precomp_sel_lo}),
        .direct_toggle(direct_toggle),
        .write_ff(encoded_write_out)
    );

    // Address mark: search when enabled and not writing
    assign searching = !mark_search_enable_n && write_gate_n;
    assign mark_found_oe_n = ~searching;
    assign mark_write_enable = in_write &&
        !mark_search_enable_n;

    // Found mark held low until the enable returns high
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            mark_found_n <= 1'b1;
        else if (clk_en)
        begin
            if (mark_search_enable_n)
                mark_found_n <= 1'b1;
            else if (searching && mark_hit)
                mark_found_n <= 1'b0;
        end
    end

    // Serial read data driven only in read mode
    assign serial_read_oe_n = ~in_read;

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            serial_read_out <= 1'b0;
        else if (clk_en && in_read && read_bit_valid)
            serial_read_out <= read_bit_in;
    end

    // Window shift size and side, applied in read mode only
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            window_shift_pct <= 5'h00;
            window_shift_late <= 1'b0;
        end
        else if (clk_en)
        begin
            if (in_read)
            begin
                window_shift_pct <= shift_pct({window_shift_sel2,
                    window_shift_sel1, window_shift_sel0});
                window_shift_late <= window_shift_dir;
            end
            else
            begin
                window_shift_pct <= 5'h00;
                window_shift_late <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rll_pcomp.v
// Write precompensation and the write data flip-flop.
// Assumes code ones are spaced wider than the longest shift delay.
`timescale 1ns/1ps
`default_nettype none
`include "rll_consts.vh"
module rll_pcomp (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    input wire clk_en,
    // Code bit stream on reference ticks
    input wire bit_tick,
    input wire code_bit,
    input wire [1:0] sel,
    // Direct toggle request
    input wire direct_toggle,
    // Write data flip-flop
    output reg write_ff
);
    reg [4:0] win_q;
    reg [3:0] dly_q;
    reg busy_q;
    wire early = (win_q == 5'b10100);
    wire late = (win_q == 5'b00101);
    // Select 00 gives 3 steps down to 11 giving none
    wire [3:0] mag = {2'b00, ~sel} * {1'b0, `RLL_PCOMP_STEP};
    wire [3:0] load = late ? `RLL_PCOMP_NOM + mag :
        early ? `RLL_PCOMP_NOM - mag : `RLL_PCOMP_NOM;

    // Window shift, delay count and transition on expiry
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            win_q <= 5'h00;
            dly_q <= 4'h0;
            busy_q <= 1'b0;
            write_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (bit_tick)
                win_q <= {win_q[3:0], code_bit};
            if (bit_tick && win_q[2])
            begin
                dly_q <= load;
                busy_q <= 1'b1;
            end
            else if (busy_q && dly_q == 4'h0)
                busy_q <= 1'b0;
            else if (busy_q)
                dly_q <= dly_q - 4'h1;
            if (direct_toggle || (busy_q && dly_q == 4'h0))
                write_ff <= ~write_ff;
        end
    end
endmodule
`default_nettype wire

// >>> rll_sync_checker.sv
// Assertion checker for the RLL synchroniser control pins.
// Assumes it is bound into the top module and ticks are a cycle apart.
`timescale 1ns/1ps
`default_nettype none
module rll_sync_checker (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    // Controller pins
    input wire logic write_gate_n,
    input wire logic read_gate_n,
    input wire logic mark_search_enable_n,
    input wire logic phase_detect_enable,
    // Read side events
    input wire logic read_bit_in,
    input wire logic read_bit_valid,
    input wire logic mark_hit,
    // Outputs under watch
    input wire logic recovered_clock,
    input wire logic ref_clock_active,
    input wire logic phase_ref_is_read,
    input wire logic decode_from_vco,
    input wire logic phase_detect_on,
    input wire logic serial_read_out,
    input wire logic serial_read_oe_n,
    input wire logic mark_found_n,
    input wire logic mark_found_oe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Gates asking for read mode
    wire rd_gates = !read_gate_n && write_gate_n;

    // Address mark pin drive, latch and clear
    property p_mark_oe;
        mark_found_oe_n == (mark_search_enable_n | ~write_gate_n);
    endproperty
    a_mark_oe: assert property (p_mark_oe)
        else $error("mark detect drive enable wrong");
    property p_mark_set;
        clk_en && mark_hit && !mark_search_enable_n && write_gate_n &&
            !$past(reset) && !$past(mark_search_enable_n) |=> !mark_found_n;
    endproperty
    a_mark_set: assert property (p_mark_set)
        else $error("found mark not reported");
    property p_mark_hold;
        !mark_found_n && !mark_search_enable_n |=> !mark_found_n;
    endproperty
    a_mark_hold: assert property (p_mark_hold)
        else $error("found mark dropped early");
    property p_mark_clr;
        clk_en && mark_search_enable_n |=> mark_found_n;
    endproperty
    a_mark_clr: assert property (p_mark_clr)
        else $error("found mark not cleared");

    // Mode decode and the serial read pin
    property p_read_on;
        clk_en && rd_gates |=> !serial_read_oe_n && phase_ref_is_read;
    endproperty
    a_read_on: assert property (p_read_on)
        else $error("read mode not entered");
    property p_read_off;
        clk_en && !rd_gates |=> serial_read_oe_n && !phase_ref_is_read;
    endproperty
    a_read_off: assert property (p_read_off)
        else $error("read pin driven outside read mode");
    property p_read_data;
        clk_en && read_bit_valid && rd_gates && phase_ref_is_read |=>
            serial_read_out == $past(read_bit_in);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read bit not passed on");

    // Clock source selection
    property p_coast;
        phase_detect_on == phase_detect_enable;
    endproperty
    a_coast: assert property (p_coast)
        else $error("phase detector state wrong");
    property p_ref_act;
        ref_clock_active != decode_from_vco;
    endproperty
    a_ref_act: assert property (p_ref_act)
        else $error("reference active flag wrong");
    property p_swap;
        $rose(decode_from_vco) |-> phase_ref_is_read && phase_detect_enable;
    endproperty
    a_swap: assert property (p_swap)
        else $error("vco taken outside locked read");
    property p_rc_glitch;
        $changed(recovered_clock) |=> $stable(recovered_clock) [*5];
    endproperty
    a_rc_glitch: assert property (p_rc_glitch)
        else $error("read clock pulse too short");
endmodule
bind rll_endec_sync rll_sync_checker u_chk (.*);
`default_nettype wire

// >>> test_rll17_endec_sync_control.sv
// Self-checking bench for the RLL synchroniser control block.
// Assumes the controller model on the gates and NRZ write pins.
`timescale 1ns/1ps
`default_nettype none
module test_rll17_endec_sync_control;
    typedef struct {string nm; int k; logic [7:0] e;} rll_note_t;
    logic clk_sys = 0, reset = 1, clk_en = 1, direct_write_n = 1;
    logic mark_search_enable_n = 1, phase_detect_enable = 1, mark_hit = 0;
    logic ref_tick = 0, vco_tick = 0, read_pulse = 0, read_bit_in = 0;
    logic read_bit_valid = 0, precomp_sel_lo = 1, precomp_sel_hi = 1;
    logic window_shift_sel0 = 1, window_shift_sel1 = 1;
    logic window_shift_sel2 = 1, window_shift_dir = 0, direct = 0, dbit = 1;
    logic write_gate_n, read_gate_n, write_clock_tick, serial_write_in;
    logic encoded_write_out, recovered_clock, ref_clock_active;
    logic phase_ref_is_read, decode_from_vco, phase_detect_on;
    logic serial_read_out, serial_read_oe_n, mark_found_n, mark_found_oe_n;
    logic mark_write_enable, window_shift_late, out_p = 0, rc_p = 0;
    logic [4:0] window_shift_pct;
    logic [1:0] mode = 0;
    int error_cnt = 0, n_tests = 0, tc = 0, tog_n = 0, iv_a = 0, iv_b = 0;
    int t_out = 0, rc_half = 0, t_rc = 0, seed, k;
    rll_note_t q[$];
    wire [9:0] bits = {window_shift_late, serial_read_oe_n, phase_ref_is_read,
        mark_found_oe_n, mark_found_n, mark_write_enable, ref_clock_active,
        decode_from_vco, serial_read_out, phase_detect_on};

    rll_endec_sync dut (.*);
    rll_ctl_model u_ctl (
        .clk_sys(clk_sys),
        .mode(mode),
        .direct(direct),
        .dbit(dbit),
        .write_gate_n(write_gate_n),
        .read_gate_n(read_gate_n),
        .write_clock_tick(write_clock_tick),
        .serial_write_in(serial_write_in)
    );

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    // Ticks, plus toggle spacing of write data and read clock
    always @(posedge clk_sys)
    begin
        #1;
        tc++;
        ref_tick = (tc % 8 == 0);
        vco_tick = (tc % 5 == 0);
        if (encoded_write_out !== out_p)
        begin
            iv_b = iv_a;
            iv_a = tc - t_out;
            t_out = tc;
            tog_n++;
        end
        if (recovered_clock !== rc_p)
        begin
            rc_half = tc - t_rc;
            t_rc = tc;
        end
        out_p = encoded_write_out;
        rc_p = recovered_clock;
    end

    function automatic logic [7:0] obs(int k);
        if (k < 10)
            return {7'h0, bits[k]};
        if (k == 10)
            return {3'h0, window_shift_pct};
        if (k == 11)
            return 8'(iv_a < iv_b ? iv_a : iv_b);
        if (k == 12)
            return 8'(tog_n);
        return 8'(rc_half);
    endfunction

    function automatic logic [7:0] pct_of(logic [2:0] s);
        case (s)
            3'h7: return 8'h00;
            3'h6: return 8'h04;
            3'h5: return 8'h08;
            3'h4: return 8'h0c;
            3'h3: return 8'h0f;
            3'h2: return 8'h12;
            3'h1: return 8'h14;
            default: return 8'h16;
        endcase
    endfunction

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic ex(string nm, int k, logic [7:0] e);
        q.push_back('{nm, k, e});
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse(int n);
        repeat (n)
        begin
            read_pulse = 1;
            cyc(1);
            read_pulse = 0;
            cyc(1);
        end
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Takes the oldest note and compares it with the outputs
    always
    begin
        wait (q.size() > 0);
        check(q[0].nm, obs(q[0].k), q[0].e);
        void'(q.pop_front());
    end

    // Hang guard, about seven times the expected run
    initial
    begin
        #100000;
        error_cnt++;
        conclude;
    end

    // Main sequence
    initial
    begin
        seed = $urandom(86742);
        cyc(5);
        reset = 0;
        cyc(2);
        ex("ref_act", 3, 1);
        ex("mark_n", 5, 1);
        ex("pd_on", 0, 1);
        mark_search_enable_n = 0;
        for (int m = 0; m < 4; m++)
        begin
            mode = m;
            cyc(3);
            ex("rd_mode", 7, m == 1);
            ex("rd_oe_n", 8, m != 1);
            ex("mark_oe_n", 6, m > 1);
            ex("mark_wr", 4, m == 2);
        end
        mode = 1;
        cyc(3);
        for (int i = 0; i < 16; i++)
        begin
            {window_shift_sel2, window_shift_sel1, window_shift_sel0} = i[2:0];
            window_shift_dir = 1'($urandom);
            read_bit_in = 1'($urandom);
            read_bit_valid = 1;
            cyc(1);
            read_bit_valid = 0;
            cyc(1);
            ex("pct", 10, pct_of(i[2:0]));
            ex("late", 9, window_shift_dir);
            ex("rd_data", 1, read_bit_in);
        end
        phase_detect_enable = 0;
        pulse(19);
        cyc(200);
        ex("ref_act", 3, 1);
        ex("pd_on", 0, 0);
        ex("rc_half", 13, 48);
        mode = 0;
        cyc(3);
        mode = 1;
        phase_detect_enable = 1;
        cyc(3);
        pulse(18);
        cyc(100);
        ex("ref_act", 3, 1);
        pulse(1);
        cyc(200);
        ex("dec_vco", 2, 1);
        ex("rc_half", 13, 30);
        mode = 0;
        cyc(200);
        ex("ref_act", 3, 1);
        ex("rc_half", 13, 48);
        clk_en = 0;
        mark_hit = 1;
        cyc(2);
        ex("mark_n", 5, 1);
        clk_en = 1;
        cyc(1);
        mark_hit = 0;
        cyc(2);
        ex("mark_n", 5, 0);
        ex("mark_oe_n", 6, 0);
        mode = 2;
        cyc(3);
        ex("mark_oe_n", 6, 1);
        mode = 0;
        mark_search_enable_n = 1;
        cyc(3);
        ex("mark_n", 5, 1);
        mode = 2;
        direct_write_n = 0;
        direct = 1;
        cyc(4);
        tog_n = 0;
        k = 3 + $urandom % 6;
        repeat (k)
        begin
            dbit = 0;
            cyc(3);
            dbit = 1;
            cyc(3);
        end
        ex("toggles", 12, 8'(k));
        direct = 0;
        direct_write_n = 1;
        mode = 0;
        cyc(60);
        for (int s = 0; s < 4; s++)
        begin
            {precomp_sel_hi, precomp_sel_lo} = s[1:0];
            mode = 2;
            cyc(400);
            ex("iv_min", 11, 8'(10 + 2 * s));
            ex("iv_min", 11, 8'(10 + 2 * s));
            mode = 0;
            cyc(60);
        end
        mode = 3;
        cyc(60);
        tog_n = 0;
        cyc(100);
        ex("toggles", 12, 0);
        cyc(2);
        conclude;
    end
endmodule
`default_nettype wire
